// *** rtl/scpg_port.sv ***
// Purpose: Serial command front end with general pin port register
// Assumes: Host drives cs_n, sclk, din; sclk idles high, data sampled on rising edge
// Notes: Only the port register is held here; other registers are offered on a side port
module scpg_port (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Serial pins
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic din,
    output logic dout,
    // General pins: input, output, output enable (low drives)
    input wire logic gp_pin_a_in,
    input wire logic gp_pin_b_in,
    output logic gp_pin_a_out,
    output logic gp_pin_b_out,
    output logic gp_pin_a_oe_n,
    output logic gp_pin_b_oe_n,
    // Ready and status
    input wire logic [7:0] chan_unread,
    input wire logic [7:0] chan_enabled,
    output logic rdy_n,
    output logic low_power_select,
    output logic sync_enable,
    output logic sync_pulse,
    output logic device_reset,
    // Other registers
    output logic [5:0] reg_addr,
    output logic [2:0] reg_chan,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    typedef enum logic [1:0] {ST_CMD, ST_WRITE, ST_READ} scpg_state_type;

    logic [3:0] pins_s;
    logic cs_s, sclk_s, din_s, gpa_s, gpb_s;
    logic sclk_d_r, rise, fall, active, soft_rst;
    scpg_state_type state_r;
    logic [7:0] shift_r, tx_r, port_r;
    logic [2:0] bit_r;
    logic [5:0] ones_r;
    logic [5:0] addr_r;
    logic init_r, rst_hold_r, gpb_d_r;
    logic port_wr;

    scpg_sync #(.WIDTH(4)) u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .async_in({cs_n, sclk, din, gp_pin_a_in}),
        .sync_out(pins_s)
    );
    scpg_sync #(.WIDTH(1)) u_sync_b (
        .clock(clock),
        .rst_n(rst_n),
        .async_in(gp_pin_b_in),
        .sync_out(gpb_s)
    );
    assign {cs_s, sclk_s, din_s, gpa_s} = pins_s;
    assign active = !cs_s;
    assign rise = active && sclk_s && !sclk_d_r;
    assign fall = active && !sclk_s && sclk_d_r;
    assign soft_rst = rst_hold_r;
    // Last data bit of a write aimed at the port register
    assign port_wr = rise && state_r == ST_WRITE && addr_r == scpg_pkg::ADDR_PORT
        && bit_r == 3'(scpg_pkg::BYTE_BITS - 1);

    function automatic logic [7:0] port_read(input logic [7:0] p, input logic a, input logic b);
        logic [7:0] v;
        v = p;
        if (p[scpg_pkg::PORT_A_DIR])
            v[scpg_pkg::PORT_A_LEVEL] = a;
        if (p[scpg_pkg::PORT_B_DIR])
            v[scpg_pkg::PORT_B_LEVEL] = b;
        return v;
    endfunction

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            sclk_d_r <= 1'b1;
        else
            sclk_d_r <= sclk_s;
    end

    // ------------------------------------------------------------
    // Resynchronisation by a run of ones
    // ------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (!rst_n || soft_rst || cs_s)
            ones_r <= '0;
        else if (rise)
        begin
            if (!din_s)
                ones_r <= '0;
            else if (ones_r < 6'(scpg_pkg::RESYNC_ONES))
                ones_r <= ones_r + 6'h01;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            rst_hold_r <= 1'b0;
        else
            rst_hold_r <= rise && din_s && (ones_r == 6'(scpg_pkg::RESYNC_ONES - 1));
    end
    assign device_reset = rst_hold_r;

    // ------------------------------------------------------------
    // Command and data phase sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (!rst_n || soft_rst)
        begin
            state_r <= ST_CMD;
            bit_r <= '0;
            shift_r <= '0;
            addr_r <= '0;
        end
        else if (rise)
        begin
            shift_r <= {shift_r[6:0], din_s};
            bit_r <= bit_r + 3'h1;
            if (bit_r == 3'(scpg_pkg::BYTE_BITS - 1))
            begin
                case (state_r)
                    ST_CMD:
                    begin
                        addr_r <= {shift_r[4:0], din_s};
                        state_r <= shift_r[scpg_pkg::CMD_RW_BIT-1] ? ST_READ : ST_WRITE;
                    end
                    ST_WRITE, ST_READ: state_r <= ST_CMD;
                    default: state_r <= ST_CMD;
                endcase
            end
        end
    end

    // Byte strobes: write towards the other registers only, read for any address including the port
    always_ff @(posedge clock)
    begin
        if (!rst_n || soft_rst)
        begin
            reg_wr <= 1'b0;
            reg_rd <= 1'b0;
            reg_wdata <= '0;
        end
        else
        begin
            reg_wr <= rise && state_r == ST_WRITE && bit_r == 3'(scpg_pkg::BYTE_BITS - 1)
                && addr_r != scpg_pkg::ADDR_PORT;
            reg_rd <= rise && state_r == ST_CMD && bit_r == 3'(scpg_pkg::BYTE_BITS - 1)
                && shift_r[scpg_pkg::CMD_RW_BIT-1];
            if (rise && bit_r == 3'(scpg_pkg::BYTE_BITS - 1))
                reg_wdata <= {shift_r[6:0], din_s};
        end
    end
    assign reg_addr = addr_r;
    assign reg_chan = addr_r[scpg_pkg::CHAN_BITS-1:0];

    // ------------------------------------------------------------
    // Read shifter, first bit presented at command end
    // ------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (!rst_n || soft_rst)
            tx_r <= '0;
        else if (reg_rd)
            tx_r <= (addr_r == scpg_pkg::ADDR_PORT) ? port_read(port_r, gpa_s, gpb_s)
                : reg_rdata;
        else if (fall && state_r == ST_READ && bit_r != 3'h0)
            tx_r <= {tx_r[6:0], 1'b0};
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            dout <= 1'b0;
        else
            dout <= (state_r == ST_READ) ? tx_r[7] : 1'b0;
    end

    // ------------------------------------------------------------
    // Port register
    // ------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (!rst_n || soft_rst)
            init_r <= 1'b1;
        else
            init_r <= 1'b0;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            port_r <= scpg_pkg::PORT_RESET;
        else if (init_r || soft_rst)
            port_r <= scpg_pkg::PORT_RESET
                | (gpb_s ? scpg_pkg::PORT_INPUT_WEIGHT : 8'h00);
        else if (port_wr)
            port_r <= {shift_r[6:0], din_s} & scpg_pkg::PORT_WRITE_MASK;
        else
        begin
            if (port_r[scpg_pkg::PORT_A_DIR])
                port_r[scpg_pkg::PORT_A_LEVEL] <= gpa_s;
            if (port_r[scpg_pkg::PORT_B_DIR])
                port_r[scpg_pkg::PORT_B_LEVEL] <= gpb_s;
        end
    end

    assign gp_pin_a_out = port_r[scpg_pkg::PORT_A_LEVEL];
    assign gp_pin_b_out = port_r[scpg_pkg::PORT_B_LEVEL];
    assign gp_pin_a_oe_n = port_r[scpg_pkg::PORT_A_DIR];
    assign gp_pin_b_oe_n = port_r[scpg_pkg::PORT_B_DIR] | port_r[scpg_pkg::PORT_SYNC_EN];
    assign low_power_select = port_r[scpg_pkg::PORT_LOWPWR];
    assign sync_enable = port_r[scpg_pkg::PORT_SYNC_EN];

    // Sync input edge on the shared pin
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            gpb_d_r <= 1'b1;
            sync_pulse <= 1'b0;
        end
        else
        begin
            gpb_d_r <= gpb_s;
            sync_pulse <= sync_enable && gpb_d_r && !gpb_s;
        end
    end

    // Ready pin function
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            rdy_n <= 1'b1;
        else if (port_r[scpg_pkg::PORT_READY_PIN_FUNCTION])
            rdy_n <= !((chan_unread & chan_enabled) == chan_enabled
                && chan_enabled != 8'h00);
        else
            rdy_n <= !(|chan_unread);
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    port_reset_a: assert property (@(posedge clock) disable iff (!rst_n)
        init_r |=> port_r[5:4] == 2'b11 && !port_r[3] && !port_r[0])
        else $error("port reset value wrong");
    dir_oe_a: assert property (@(posedge clock) disable iff (!rst_n || soft_rst)
        port_wr |=> gp_pin_a_oe_n == $past(shift_r[scpg_pkg::PORT_A_DIR-1]))
        else $error("pin a enable mismatch");
    resync_a: assert property (@(posedge clock) disable iff (!rst_n)
        rst_hold_r |=> state_r == ST_CMD && port_r[5:4] == 2'b11)
        else $error("resync did not reset");
    rw_sel_a: assert property (@(posedge clock) disable iff (!rst_n || soft_rst)
        rise && state_r == ST_CMD && bit_r == 3'h7 && shift_r[5] |=> state_r == ST_READ)
        else $error("read not selected");
    ret_cmd_a: assert property (@(posedge clock) disable iff (!rst_n || soft_rst)
        rise && state_r != ST_CMD && bit_r == 3'h7 |=> state_r == ST_CMD)
        else $error("no return to command");
    rdy_any_a: assert property (@(posedge clock) disable iff (!rst_n)
        !port_r[3] && |chan_unread |=> !rdy_n)
        else $error("ready not low");
    addr_a: assert property (@(posedge clock) disable iff (!rst_n || soft_rst)
        rise && state_r == ST_CMD && bit_r == 3'h7 |=> reg_addr == $past({shift_r[4:0], din_s}))
        else $error("address not captured");
    lowpwr_a: assert property (@(posedge clock) disable iff (!rst_n || soft_rst)
        port_wr |=> low_power_select == $past(shift_r[scpg_pkg::PORT_LOWPWR-1]))
        else $error("low power flag wrong");
    cmd_read_c: cover property (@(posedge clock) reg_rd);
    cmd_write_c: cover property (@(posedge clock) reg_wr);
    resync_c: cover property (@(posedge clock) device_reset);
endmodule // scpg_port

// *** rtl/scpg_pkg.sv ***
// Purpose: Shared constants for the serial command port and pin port block
// Assumes: 8-bit command byte, 8-bit port register
// Notes: Offsets, field positions and reset values of the port logic
package scpg_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [5:0] ADDR_COMMAND = 6'h00;
    localparam logic [5:0] ADDR_PORT = 6'h01;
    localparam logic [5:0] ADDR_MODE_BASE = 6'h38;
    // ------------------------------------------------------------
    // Command byte fields
    // ------------------------------------------------------------
    localparam int CMD_RW_BIT = 6;
    localparam int CMD_ZERO_BIT = 7;
    localparam int CHAN_BITS = 3;
    // ------------------------------------------------------------
    // Port register fields
    // ------------------------------------------------------------
    localparam int PORT_A_LEVEL = 7;
    localparam int PORT_B_LEVEL = 6;
    localparam int PORT_A_DIR = 5;
    localparam int PORT_B_DIR = 4;
    localparam int PORT_READY_PIN_FUNCTION = 3;
    localparam int PORT_LOWPWR = 2;
    localparam int PORT_SYNC_EN = 0;
    localparam logic [7:0] PORT_RESET = 8'h30;
    localparam logic [7:0] PORT_INPUT_WEIGHT = 8'h40;
    localparam logic [7:0] PORT_WRITE_MASK = 8'hfd;
    // ------------------------------------------------------------
    // Framing
    // ------------------------------------------------------------
    localparam int RESYNC_ONES = 32;
    localparam int BYTE_BITS = 8;
    localparam int LOWPWR_MCLK_MHZ = 4;
endpackage : scpg_pkg

// *** rtl/scpg_sync.sv ***
// Purpose: Two-flop synchroniser for a bundle of pin inputs
// Assumes: Inputs asynchronous to clock
// Notes: First stage read only by the second
module scpg_sync #(
    parameter int WIDTH = 4
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Pins
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            meta_r <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule // scpg_sync

// *** tb/scpg_host.sv ***
// Purpose: Host serial port model driving the command front end
// Assumes: sclk idles high, device samples din on the rising edge
// Notes: Released din shows the inverse of its last bit
module scpg_host (
    // Clock
    input wire logic clock,
    // Serial pins
    output logic cs_n,
    output logic sclk,
    output logic din,
    input wire logic dout
);
    timeunit 1ns;
    timeprecision 1ps;
    event rx_done;
    logic [7:0] rx_byte;
    initial
    begin
        cs_n = 1'b1;
        sclk = 1'b1;
        din = 1'b0;
        rx_byte = 8'h00;
    end
    task automatic half();
        repeat (10) @(negedge clock);
    endtask
    task automatic put_bit(input logic b);
        din = b;
        sclk = 1'b0;
        half();
        sclk = 1'b1;
        rx_byte = {rx_byte[6:0], dout};
        half();
    endtask
    task automatic frame(input logic [7:0] cmd, input logic [7:0] data);
        cs_n = 1'b0;
        half();
        for (int i = 7; i >= 0; i--)
            put_bit(i == 7 ? 1'b0 : cmd[i]);
        for (int i = 7; i >= 0; i--)
            put_bit(cmd[6] ? 1'b0 : data[i]);
        cs_n = 1'b1;
        din = ~din;
        half();
        if (cmd[6])
            -> rx_done;
    endtask
    task automatic resync();
        cs_n = 1'b0;
        half();
        repeat (32) put_bit(1'b1);
        cs_n = 1'b1;
        din = ~din;
        half();
    endtask
endmodule // scpg_host

// *** tb/test_serial_command_port_and_gpio.sv ***
// Purpose: Self-checking bench for the serial command port and pin port
// Assumes: Host model drives the serial pins
// Notes: Register events and read bytes checked against queued notes
module test_serial_command_port_and_gpio;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, rst_n, cs_n, sclk, din, dout, rdy_n, lps, sync_en, sync_pulse, dev_rst;
    logic pa_in, pb_in, pa_out, pb_out, pa_oe_n, pb_oe_n, pa_ext, pb_ext, reg_wr, reg_rd;
    logic [7:0] unread, enabled, rdata, wdata, d, e;
    logic [5:0] addr, wa;
    logic [2:0] chan;
    integer seed = 32'hbae7bf0a;
    int failures = 0;
    int n_compared = 0;
    int n_rst = 0;
    int n_sync = 0;
    logic [16:0] exp_wr[$];
    logic [5:0] exp_rd[$];
    logic [7:0] exp_rx[$];
    assign pa_in = pa_oe_n ? pa_ext : pa_out;
    assign pb_in = pb_oe_n ? pb_ext : pb_out;
    scpg_port dut (.clock(clock), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .din(din),
        .dout(dout), .gp_pin_a_in(pa_in), .gp_pin_b_in(pb_in), .gp_pin_a_out(pa_out),
        .gp_pin_b_out(pb_out), .gp_pin_a_oe_n(pa_oe_n), .gp_pin_b_oe_n(pb_oe_n),
        .chan_unread(unread), .chan_enabled(enabled), .rdy_n(rdy_n),
        .low_power_select(lps), .sync_enable(sync_en), .sync_pulse(sync_pulse),
        .device_reset(dev_rst), .reg_addr(addr), .reg_chan(chan), .reg_wr(reg_wr),
        .reg_wdata(wdata), .reg_rd(reg_rd), .reg_rdata(rdata));
    scpg_host u_host (.clock(clock), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout));
    task automatic chk(input string nm, input logic [23:0] ex, input logic [23:0] g);
        n_compared++;
        if (g !== ex)
        begin
            failures++;
            $display("FAIL %s expected %h seen %h", nm, ex, g);
        end
    endtask
    task automatic print_verdict();
        if (failures == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(negedge clock);
    endtask
    always @(negedge clock)
    begin
        if (dev_rst === 1'b1)
            n_rst++;
        if (sync_pulse === 1'b1)
            n_sync++;
        if (reg_wr === 1'b1 && addr !== scpg_pkg::ADDR_PORT)
            chk("reg_wr", exp_wr.size() ? exp_wr.pop_front() : 'x, {addr, chan, wdata});
        if (reg_rd === 1'b1 && addr !== scpg_pkg::ADDR_PORT)
            chk("reg_rd", exp_rd.size() ? exp_rd.pop_front() : 'x, addr);
    end
    always @(u_host.rx_done)
        chk("rx_byte", exp_rx.size() ? exp_rx.pop_front() : 'x, u_host.rx_byte);
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    initial
    begin
        #500us;
        failures++;
        print_verdict();
    end
    initial
    begin
        rst_n = 1'b0;
        pa_ext = 1'($random(seed));
        pb_ext = pa_ext;
        unread = 8'h00;
        enabled = 8'h00;
        rdata = 8'h00;
        wait_n(10);
        rst_n = 1'b1;
        wait_n(6);
        exp_rx.push_back({pa_ext, pa_ext, 6'h30});
        u_host.frame(8'h41, 8'h00);
        repeat (6)
        begin
            d = 8'($random(seed));
            d[1] = 1'b0;
            d[0] = 1'b0;
            {pa_ext, pb_ext} = 2'($random(seed));
            unread = 8'($random(seed));
            enabled = 8'($random(seed));
            u_host.frame(8'h01, d);
            wait_n(4);
            e[7] = d[5] ? pa_ext : d[7];
            e[6] = d[4] ? pb_ext : d[6];
            chk("oe_a", d[5], pa_oe_n);
            chk("oe_b", d[4], pb_oe_n);
            chk("pin_a", e[7], pa_in);
            chk("pin_b", e[6], pb_in);
            chk("low_power", d[2], lps);
            chk("sync_en", 1'b0, sync_en);
            e[0] = d[3] ? (|enabled && (unread & enabled) == enabled) : |unread;
            chk("rdy_n", !e[0], rdy_n);
            exp_rx.push_back({e[7:6], d[5:2], 2'b00});
            u_host.frame(8'h41, 8'h00);
        end
        pb_ext = 1'b1;
        u_host.frame(8'h01, 8'h31);
        wait_n(4);
        chk("sync_en", 1'b1, sync_en);
        chk("oe_b", 1'b1, pb_oe_n);
        pb_ext = 1'b0;
        wait_n(8);
        chk("sync_pulse", 24'h1, 24'(n_sync));
        for (int ch = 0; ch < 8; ch++)
        begin
            wa = (ch[0] ? 6'h38 : 6'h28) | 6'(ch);
            d = 8'($random(seed));
            exp_wr.push_back({wa, 3'(ch), d});
            u_host.frame({2'b00, wa}, d);
            rdata = 8'($random(seed));
            exp_rd.push_back(6'h20 | 6'(ch));
            exp_rx.push_back(rdata);
            u_host.frame(8'h60 | 8'(ch), 8'h00);
        end
        pa_ext = 1'b1;
        pb_ext = 1'b1;
        // Run of ones also decodes two read commands to the top address
        repeat (2) exp_rd.push_back(6'h3f);
        u_host.resync();
        chk("dev_rst", 24'h1, 24'(n_rst));
        exp_rx.push_back(8'hf0);
        u_host.frame(8'h41, 8'h00);
        wait_n(2);
        chk("queues", 24'h0, 24'(exp_wr.size() + exp_rd.size() + exp_rx.size()));
        print_verdict();
    end
endmodule // test_serial_command_port_and_gpio
